//--- hdl/mgc_gateway_check.sv
// setup block intake, validation, reply block and per-port error bookkeeping
// assumes the backplane side hands one 16-bit word per cycle with its index
`timescale 1ns/1ps
module mgc_gateway_check (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     reset_n,
   // write block from controller
   input  wire logic                     bw_valid,
   input  wire logic [5:0]               bw_index,
   input  wire logic [15:0]              bw_word,
   input  wire logic                     bw_last,
   output logic                          bw_ready,
   // reply block to controller
   output logic                          br_valid,
   output logic [5:0]                    br_index,
   output logic [15:0]                   br_word,
   input  wire logic                     br_ready,
   // master side events per port
   input  wire logic [1:0]               evt_valid,
   input  wire mgc_pkg::mgc_rsp_s [1:0]  rsp_in,
   input  wire logic [1:0]               cmd_chk,
   input  wire mgc_pkg::mgc_cmd_s [1:0]  cmd_in,
   input  wire logic [1:0][7:0]          exp_addr,
   input  wire logic [1:0][7:0]          exp_func,
   input  wire logic [1:0]               cmd_adv,
   output logic [1:0][6:0]               cmd_idx,
   output logic [1:0]                    cmd_due,
   // slave side requests per port
   input  wire logic [1:0]               req_valid,
   input  wire logic [1:0][7:0]          req_func,
   input  wire logic [1:0]               pass_thru_en,
   output logic [1:0]                    slv_rsp_valid,
   output logic [1:0][15:0]              slv_exc,
   output logic [1:0]                    slv_fwd,
   // status per port
   output logic [1:0][15:0]              cur_err,
   output logic [1:0][15:0]              last_err,
   output logic [1:0]                    port_is_slave
);
   mgc_pkg::mgc_blk_e      state_q;
   logic [15:0]            cfg_q [64];
   logic [15:0]            mod_err_q;
   logic [1:0][15:0]       port_err_q;
   logic [1:0][15:0]       perr;
   logic [1:0][15:0]       ecode;
   logic [5:0]             rd_idx_q;
   logic [15:0]            br_word_q;
   logic [15:0]            id_now;
   logic [7:0]             mod_err_d;
   logic [1:0][15:0]       act_type_q;
   logic [1:0][6:0]        act_cnt_q;
   logic [1:0][6:0]        idx_q;
   logic [1:0][1:0]        pass_q;
   logic [1:0][99:0]       fail_q;
   logic [1:0][15:0]       cur_q;
   logic [1:0][15:0]       last_q;
   logic [1:0][15:0]       exc_q;
   logic [1:0]             fwd_q;
   logic [1:0]             srv_q;

   // four area checks: start beyond, start negative, count negative, end beyond
   function automatic logic [3:0] area_err(input logic [15:0] start,
                                           input logic [15:0] count);
      logic signed [17:0] s;
      logic signed [17:0] c;
      logic signed [17:0] db;
      s = 18'($signed(start));
      c = 18'($signed(count));
      db = 18'($signed({2'b00, mgc_pkg::DB_WORDS}));
      area_err[0] = s > db;
      area_err[1] = s < 0;
      area_err[2] = c < 0;
      area_err[3] = (s + c) > db;
   endfunction

   function automatic mgc_pkg::mgc_port_cfg_s port_cfg(input logic [5:0] base);
      logic [5:0] b;
      b = base;
      port_cfg.ptype    = cfg_q[b + 6'd1];
      port_cfg.fflag    = cfg_q[b + 6'd2];
      port_cfg.fstart   = cfg_q[b + 6'd3];
      port_cfg.foff     = cfg_q[b + 6'd4];
      port_cfg.proto    = cfg_q[b + 6'd5];
      port_cfg.baud     = cfg_q[b + 6'd6];
      port_cfg.parity   = cfg_q[b + 6'd7];
      port_cfg.dbits    = cfg_q[b + 6'd8];
      port_cfg.sbits    = cfg_q[b + 6'd9];
      port_cfg.slave_id = cfg_q[b + 6'd13];
      port_cfg.bin_off  = cfg_q[b + 6'd14];
      port_cfg.win_off  = cfg_q[b + 6'd15];
      port_cfg.bout_off = cfg_q[b + 6'd16];
      port_cfg.hold_off = cfg_q[b + 6'd17];
      port_cfg.cmd_cnt  = cfg_q[b + 6'd18];
   endfunction

   function automatic logic [15:0] reply_word(input logic [5:0] idx);
      case (idx)
         mgc_pkg::RB_ID:      reply_word = mgc_pkg::RSP_BLK_ID;
         mgc_pkg::RB_ECHO:    reply_word = mgc_pkg::CFG_BLK_ID;
         mgc_pkg::RB_MOD_ERR: reply_word = mod_err_q;
         mgc_pkg::RB_P1_ERR:  reply_word = port_err_q[0];
         mgc_pkg::RB_P2_ERR:  reply_word = port_err_q[1];
         default:             reply_word = 16'h0000;
      endcase
   endfunction

   // a block whose id word came last still has its id judged
   assign id_now = (bw_index == mgc_pkg::OFS_ID) ? bw_word : cfg_q[mgc_pkg::OFS_ID];
   assign mod_err_d[3:0] = area_err(cfg_q[mgc_pkg::OFS_WR_STRT],
                                    cfg_q[mgc_pkg::OFS_WR_CNT]);
   assign mod_err_d[7:4] = area_err(cfg_q[mgc_pkg::OFS_RD_STRT],
                                    cfg_q[mgc_pkg::OFS_RD_CNT]);

   assign bw_ready = (state_q == mgc_pkg::ST_COLLECT);
   assign br_valid = (state_q == mgc_pkg::ST_SEND);
   assign br_index = rd_idx_q;
   assign br_word  = br_word_q;

   // block sequencing; writes are refused while a check or reply is under way
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q <= mgc_pkg::ST_COLLECT;
         rd_idx_q <= 6'h00;
         br_word_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            mgc_pkg::ST_COLLECT:
            begin
               if (bw_valid && bw_last && (id_now == mgc_pkg::CFG_BLK_ID))
                  state_q <= mgc_pkg::ST_CHECK;
            end
            mgc_pkg::ST_CHECK:
            begin
               state_q <= mgc_pkg::ST_SEND;
               rd_idx_q <= 6'h00;
               br_word_q <= reply_word(mgc_pkg::RB_ID);
            end
            mgc_pkg::ST_SEND:
            begin
               if (br_ready)
               begin
                  if (rd_idx_q == mgc_pkg::BLK_LAST)
                     state_q <= mgc_pkg::ST_COLLECT;
                  else
                  begin
                     rd_idx_q <= rd_idx_q + 6'd1;
                     br_word_q <= reply_word(rd_idx_q + 6'd1);
                  end
               end
            end
            default:
               state_q <= mgc_pkg::ST_COLLECT;
         endcase
      end
   end

   // setup word store
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < 64; i++)
            cfg_q[i] <= 16'h0000;
      end
      else if (bw_valid && bw_ready)
         cfg_q[bw_index] <= bw_word;
      else if (state_q == mgc_pkg::ST_SEND)
         cfg_q[mgc_pkg::OFS_ID] <= 16'h0000;
   end

   // error words are rebuilt whole, so no stale bit survives a new check
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         mod_err_q <= mgc_pkg::ERR_RESET;
         port_err_q <= {2{mgc_pkg::ERR_RESET}};
      end
      else if (state_q == mgc_pkg::ST_CHECK)
      begin
         mod_err_q <= {8'h00, mod_err_d};
         port_err_q <= perr;
      end
   end

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         localparam logic [5:0] BASE = (p == 0) ? mgc_pkg::OFS_PORT1 : mgc_pkg::OFS_PORT2;
         logic [6:0] nxt;
         logic       wrap;

         mgc_port_check u_check (
            .cfg (port_cfg(BASE)),
            .err (perr[p])
         );

         mgc_event_code u_code (
            .rsp      (rsp_in[p]),
            .cmd      (cmd_in[p]),
            .cmd_chk  (cmd_chk[p]),
            .exp_addr (exp_addr[p]),
            .exp_func (exp_func[p]),
            .code     (ecode[p])
         );

         // the checked settings become active even when flagged
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               act_type_q[p] <= mgc_pkg::PT_MASTER;
               act_cnt_q[p] <= 7'h00;
            end
            else if (state_q == mgc_pkg::ST_CHECK)
            begin
               act_type_q[p] <= port_cfg(BASE).ptype;
               if (port_cfg(BASE).cmd_cnt > mgc_pkg::MAX_CMDS)
                  act_cnt_q[p] <= mgc_pkg::MAX_CMDS[6:0];
               else
                  act_cnt_q[p] <= port_cfg(BASE).cmd_cnt[6:0];
            end
         end

         assign wrap = (act_cnt_q[p] == 7'h00) || (idx_q[p] + 7'd1 >= act_cnt_q[p]);
         assign nxt  = wrap ? 7'h00 : idx_q[p] + 7'd1;

         // round-robin over the list; failing entries wait for the slow pass
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               idx_q[p] <= 7'h00;
               pass_q[p] <= 2'h0;
            end
            else if (state_q == mgc_pkg::ST_CHECK)
            begin
               idx_q[p] <= 7'h00;
               pass_q[p] <= 2'h0;
            end
            else if (cmd_adv[p])
            begin
               idx_q[p] <= nxt;
               if (wrap)
                  pass_q[p] <= (pass_q[p] == mgc_pkg::SLOW_PASSES) ? 2'h0 : pass_q[p] + 2'h1;
            end
         end

         always_ff @(posedge mclk)
         begin
            if (!reset_n)
               fail_q[p] <= 100'h0;
            else if (state_q == mgc_pkg::ST_CHECK)
               fail_q[p] <= 100'h0;
            else if (evt_valid[p] && (act_type_q[p] == mgc_pkg::PT_MASTER))
               fail_q[p][idx_q[p]] <= (ecode[p] != mgc_pkg::EC_NONE);
         end

         assign cmd_idx[p] = idx_q[p];
         assign cmd_due[p] = !fail_q[p][idx_q[p]] || (pass_q[p] == 2'h0);

         // status words: index for a master, code for a slave
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               cur_q[p] <= mgc_pkg::ERR_RESET;
               last_q[p] <= mgc_pkg::ERR_RESET;
            end
            else if (act_type_q[p] == mgc_pkg::PT_MASTER)
            begin
               cur_q[p] <= {9'h000, idx_q[p]};
               if (evt_valid[p] && (ecode[p] != mgc_pkg::EC_NONE))
                  last_q[p] <= {9'h000, idx_q[p]};
            end
            else if (evt_valid[p])
            begin
               cur_q[p] <= ecode[p];
               if (ecode[p] != mgc_pkg::EC_NONE)
                  last_q[p] <= ecode[p];
            end
            else if (srv_q[p])
            begin
               cur_q[p] <= exc_q[p];
               if (exc_q[p] != mgc_pkg::EC_NONE)
                  last_q[p] <= exc_q[p];
            end
         end

         // slave service: unknown functions answer illegal function
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
            begin
               srv_q[p] <= 1'b0;
               exc_q[p] <= mgc_pkg::EC_NONE;
               fwd_q[p] <= 1'b0;
            end
            else
            begin
               srv_q[p] <= req_valid[p] && (act_type_q[p] == mgc_pkg::PT_SLAVE);
               fwd_q[p] <= req_valid[p] && (act_type_q[p] == mgc_pkg::PT_SLAVE)
                           && pass_thru_en[p]
                           && (req_func[p] inside {8'h05, 8'h06, 8'h0f, 8'h10});
               if (req_valid[p])
                  exc_q[p] <= (req_func[p] inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                               8'h06, 8'h0f, 8'h10}) ? mgc_pkg::EC_NONE
                                                     : mgc_pkg::EC_ILL_FUNC;
            end
         end

         assign slv_rsp_valid[p] = srv_q[p];
         assign slv_exc[p]       = exc_q[p];
         assign slv_fwd[p]       = fwd_q[p];
         assign cur_err[p]       = cur_q[p];
         assign last_err[p]      = last_q[p];
         assign port_is_slave[p] = (act_type_q[p] == mgc_pkg::PT_SLAVE);
      end
   endgenerate
endmodule

//--- hdl/mgc_pkg.sv
// constants, field layouts, codes and carriers of the gateway setup checker
// assumes one 25 mhz clock and 16-bit backplane words, one word per transfer
// Contract
// - write block id 9000 starts setup check
// - reply block: -2, 9000, three error words
// - module bits 0-3 check write area
// - module bits 4-7 check read area
// - database of 5000 words bounds areas
// - port bit 0: type not master/slave
// - port bits 1-3: float settings invalid
// - port bits 4-8: serial settings invalid
// - port bits 9-11: id, offsets, command count
// - accepted protocol, baud, parity, bits, stops
// - rts and response delays any 16-bit value
// - report modbus exceptions 1 to 6
// - report -1, -2 and -11 link faults
// - report 253, 254, 255 response faults
// - report -41 to -46 command entry faults
// - slave port serves eight function codes
// - pass-through forwards writes to controller
// - hundred commands, failing slaves polled less
// - master status holds current and failed index
package mgc_pkg;
   localparam logic [15:0] CFG_BLK_ID  = 16'h2328;
   localparam logic [15:0] RSP_BLK_ID  = 16'hfffe;
   localparam logic [15:0] DB_WORDS    = 16'h1388;
   localparam logic [15:0] DB_LAST     = 16'h1387;
   localparam logic [15:0] ERR_RESET   = 16'h0000;
   localparam logic [5:0]  BLK_LAST    = 6'h3f;
   // setup and reply block word offsets
   localparam logic [5:0] OFS_ID = 6'h00, OFS_WR_STRT = 6'h01, OFS_WR_CNT = 6'h02;
   localparam logic [5:0] OFS_RD_STRT = 6'h03, OFS_RD_CNT = 6'h04, OFS_PORT1 = 6'h07;
   localparam logic [5:0] OFS_PORT2 = 6'h20, RB_ID = 6'h00, RB_ECHO = 6'h01;
   localparam logic [5:0] RB_MOD_ERR = 6'h02, RB_P1_ERR = 6'h03, RB_P2_ERR = 6'h04;
   // module error word: write area at bit 0, read area at bit 4
   localparam int          ME_WR_POS   = 0;
   localparam int          ME_RD_POS   = 4;
   // port error word bit positions
   localparam int PE_TYPE = 0, PE_FFLAG = 1, PE_FSTART = 2, PE_FOFF = 3;
   localparam int PE_PROTO = 4, PE_BAUD = 5, PE_PARITY = 6, PE_DBITS = 7;
   localparam int PE_SBITS = 8, PE_SLAVE = 9, PE_OFFS = 10, PE_CMDCNT = 11;
   // limits of settings
   localparam logic [15:0] PT_MASTER = 16'h0000, PT_SLAVE = 16'h0001, PROTO_MAX = 16'h0001;
   localparam logic [15:0] PARITY_MAX = 16'h0002, DBITS_MIN = 16'h0005, DBITS_MAX = 16'h0008;
   localparam logic [15:0] SBITS_MIN = 16'h0001, SBITS_MAX = 16'h0002, NODE_MAX = 16'h00ff;
   localparam logic [15:0] MAX_CMDS = 16'h0064, ENABLE_MAX = 16'h0002, SWAP_MAX = 16'h0003;
   localparam logic [1:0]  SLOW_PASSES = 2'h3;
   // baud codes; 115200 does not fit a word and is written as 1152
   localparam logic [11:0][15:0] BAUD_CODES = {
      16'h006e, 16'h0096, 16'h012c, 16'h0258, 16'h04b0, 16'h0960,
      16'h12c0, 16'h2580, 16'h4b00, 16'h9600, 16'he100, 16'h0480};
   // codes reported
   localparam logic [15:0] EC_NONE = 16'h0000, EC_ILL_FUNC = 16'h0001, EC_ILL_ADDR = 16'h0002;
   localparam logic [15:0] EC_ILL_VAL = 16'h0003, EC_DEV_FAIL = 16'h0004, EC_ACK = 16'h0005;
   localparam logic [15:0] EC_BUSY = 16'h0006, EC_NO_CTS = 16'hffff, EC_TX_TMO = 16'hfffe;
   localparam logic [15:0] EC_RSP_TMO = 16'hfff5, EC_BAD_ADDR = 16'h00fd, EC_BAD_FUNC = 16'h00fe;
   localparam logic [15:0] EC_BAD_CRC = 16'h00ff, EC_CMD_EN = 16'hffd7, EC_CMD_IADR = 16'hffd6;
   localparam logic [15:0] EC_CMD_NODE = 16'hffd5, EC_CMD_CNT = 16'hffd4, EC_CMD_FUNC = 16'hffd3;
   localparam logic [15:0] EC_CMD_SWAP = 16'hffd2;

   typedef enum logic [1:0] {ST_COLLECT, ST_CHECK, ST_SEND} mgc_blk_e;

   typedef struct packed {
      logic [15:0] ptype;
      logic [15:0] fflag;
      logic [15:0] fstart;
      logic [15:0] foff;
      logic [15:0] proto;
      logic [15:0] baud;
      logic [15:0] parity;
      logic [15:0] dbits;
      logic [15:0] sbits;
      logic [15:0] slave_id;
      logic [15:0] bin_off;
      logic [15:0] win_off;
      logic [15:0] bout_off;
      logic [15:0] hold_off;
      logic [15:0] cmd_cnt;
   } mgc_port_cfg_s;

   typedef struct packed {
      logic        cts_missing;
      logic        tx_timeout;
      logic        rsp_timeout;
      logic [7:0]  exc;
      logic [7:0]  got_addr;
      logic [7:0]  got_func;
      logic        crc_ok;
   } mgc_rsp_s;

   typedef struct packed {
      logic [15:0] enable;
      logic [15:0] int_addr;
      logic [15:0] count;
      logic [15:0] swap;
      logic [15:0] node;
      logic [15:0] func;
   } mgc_cmd_s;
endpackage

//--- hdl/mgc_port_check.sv
// setup checker for one serial port: settings in, error bitmap out
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
module mgc_port_check (
   // settings
   input  mgc_pkg::mgc_port_cfg_s cfg,
   // result
   output logic [15:0]            err
);
   logic baud_ok;

   function automatic logic in_db(input logic [15:0] v);
      in_db = !v[15] && (v < mgc_pkg::DB_WORDS);
   endfunction

   always_comb
   begin
      baud_ok = 1'b0;
      for (int i = 0; i < 12; i++)
         if (cfg.baud == mgc_pkg::BAUD_CODES[i])
            baud_ok = 1'b1;
   end

   // delay words are full 16-bit ranges, nothing to flag
   always_comb
   begin
      err = mgc_pkg::ERR_RESET;
      err[mgc_pkg::PE_TYPE]   = cfg.ptype > mgc_pkg::PT_SLAVE;
      err[mgc_pkg::PE_FFLAG]  = cfg.fflag > 16'h0001;
      err[mgc_pkg::PE_FSTART] = !in_db(cfg.fstart);
      err[mgc_pkg::PE_FOFF]   = !in_db(cfg.foff);
      err[mgc_pkg::PE_PROTO]  = cfg.proto > mgc_pkg::PROTO_MAX;
      err[mgc_pkg::PE_BAUD]   = !baud_ok;
      err[mgc_pkg::PE_PARITY] = cfg.parity > mgc_pkg::PARITY_MAX;
      err[mgc_pkg::PE_DBITS]  = (cfg.dbits < mgc_pkg::DBITS_MIN)
                                || (cfg.dbits > mgc_pkg::DBITS_MAX);
      err[mgc_pkg::PE_SBITS]  = (cfg.sbits < mgc_pkg::SBITS_MIN)
                                || (cfg.sbits > mgc_pkg::SBITS_MAX);
      err[mgc_pkg::PE_SLAVE]  = cfg.slave_id > mgc_pkg::NODE_MAX;
      err[mgc_pkg::PE_OFFS]   = !(in_db(cfg.bin_off) && in_db(cfg.win_off)
                                && in_db(cfg.bout_off) && in_db(cfg.hold_off));
      err[mgc_pkg::PE_CMDCNT] = cfg.cmd_cnt > mgc_pkg::MAX_CMDS;
   end
endmodule

//--- hdl/mgc_event_code.sv
// turns one port event (link fault, response check or command entry) into a code
// assumes at most one kind of event is being judged per strobe
`timescale 1ns/1ps
module mgc_event_code (
   // event
   input  mgc_pkg::mgc_rsp_s rsp,
   input  mgc_pkg::mgc_cmd_s cmd,
   input  logic              cmd_chk,
   // expected response header
   input  logic [7:0]        exp_addr,
   input  logic [7:0]        exp_func,
   // result
   output logic [15:0]       code
);
   logic func_ok;

   assign func_ok = (cmd.func inside {16'h0001, 16'h0002, 16'h0003, 16'h0004,
                                      16'h0005, 16'h0006, 16'h000f, 16'h0010});

   always_comb
   begin
      code = mgc_pkg::EC_NONE;
      if (cmd_chk)
      begin
         // first fault wins, in code order: enable, address, node, count, function, swap
         if (cmd.enable > mgc_pkg::ENABLE_MAX)
            code = mgc_pkg::EC_CMD_EN;
         else if (cmd.int_addr > mgc_pkg::DB_LAST)
            code = mgc_pkg::EC_CMD_IADR;
         else if (cmd.node > mgc_pkg::NODE_MAX)
            code = mgc_pkg::EC_CMD_NODE;
         else if (cmd.count == 16'h0000)
            code = mgc_pkg::EC_CMD_CNT;
         else if (!func_ok)
            code = mgc_pkg::EC_CMD_FUNC;
         else if (cmd.swap > mgc_pkg::SWAP_MAX)
            code = mgc_pkg::EC_CMD_SWAP;
      end
      else if (rsp.cts_missing)
         code = mgc_pkg::EC_NO_CTS;
      else if (rsp.tx_timeout)
         code = mgc_pkg::EC_TX_TMO;
      else if (rsp.rsp_timeout)
         code = mgc_pkg::EC_RSP_TMO;
      // a bad checksum makes the header untrustworthy, so it goes first
      else if (!rsp.crc_ok)
         code = mgc_pkg::EC_BAD_CRC;
      else if (rsp.got_addr != exp_addr)
         code = mgc_pkg::EC_BAD_ADDR;
      else if (rsp.got_func[6:0] != exp_func[6:0])
         code = mgc_pkg::EC_BAD_FUNC;
      else if (rsp.got_func[7] && (rsp.exc != 8'h00) && (rsp.exc < 8'h07))
         code = {8'h00, rsp.exc};
   end
endmodule

//--- verif/mgc_gateway_checker.sv
// reply handshake and slave answer assertions for the setup checker
// assumes a bind into mgc_gateway_check, one clock, port 0 watched
`timescale 1ns/1ps
module mgc_gateway_checker (
   // clock and reset
   input wire logic             mclk,
   input wire logic             reset_n,
   // block handshakes
   input wire logic             bw_valid, bw_last, bw_ready, br_valid, br_ready,
   input wire logic [5:0]       bw_index, br_index,
   input wire logic [15:0]      bw_word, br_word,
   // slave side
   input wire logic [1:0]       req_valid, pass_thru_en, slv_rsp_valid, slv_fwd, port_is_slave,
   input wire logic [1:0][7:0]  req_func,
   input wire logic [1:0][15:0] slv_exc
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic legal;
   assign legal = req_func[0] inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
   sequence s_id_last;
      bw_valid && bw_ready && bw_last && bw_index == 6'h00 && bw_word == mgc_pkg::CFG_BLK_ID;
   endsequence
   sequence s_head;
      br_valid && br_index == 6'h00 && br_word == mgc_pkg::RSP_BLK_ID;
   endsequence
   chk_reply_start: assert property (s_id_last |-> ##2 s_head)
      else $error("reply block did not open");
   chk_reply_hold: assert property (br_valid && !br_ready |=> br_valid && $stable(br_word))
      else $error("reply word dropped before taken");
   chk_reply_echo: assert property (br_valid && br_ready && br_index == 6'h00 |=>
      br_valid && br_index == 6'h01 && br_word == mgc_pkg::CFG_BLK_ID)
      else $error("reply echo word wrong");
   chk_spare_zero: assert property (br_valid && br_index > 6'h04 |-> br_word == 16'h0000)
      else $error("spare reply word not zero");
   chk_intake_shut: assert property (br_valid |-> !bw_ready)
      else $error("intake open during reply");
   chk_slave_answer: assert property (req_valid[0] && port_is_slave[0] |=> slv_rsp_valid[0]
      && slv_exc[0] == ($past(legal) ? 16'h0000 : 16'h0001))
      else $error("slave answer wrong");
   chk_fwd_write: assert property (req_valid[0] && port_is_slave[0] && pass_thru_en[0]
      && req_func[0] inside {8'h05, 8'h06, 8'h0f, 8'h10} |=> slv_fwd[0])
      else $error("write not forwarded");
   chk_keep_read: assert property (req_valid[0] && req_func[0] inside {[8'h01:8'h04]}
      |=> !slv_fwd[0])
      else $error("read forwarded");
endmodule
bind mgc_gateway_check mgc_gateway_checker u_chk (.*);

//--- verif/mgc_plc_model.sv
// controller model: sends a setup block top index first, drains the reply block
// assumes the gateway takes one word a cycle and offers replies under valid/ready
`timescale 1ns/1ps
module mgc_plc_model (
   // clock, reset and control
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              go,
   input  wire logic              slow,
   input  wire logic [63:0][15:0] blk,
   // write block
   output logic                   bw_valid,
   output logic [5:0]             bw_index,
   output logic [15:0]            bw_word,
   output logic                   bw_last,
   input  wire logic              bw_ready,
   // reply block
   input  wire logic              br_valid,
   input  wire logic [5:0]        br_index,
   input  wire logic [15:0]       br_word,
   output logic                   br_ready,
   output logic [63:0][15:0]      got,
   output logic [6:0]             nrx
);
   logic [1:0] tick_q;
   // released word line shows the inverse so stale data cannot pass
   assign bw_word = bw_valid ? blk[bw_index] : ~blk[bw_index];
   assign bw_last = bw_valid && bw_index == 6'h00;
   always_ff @(posedge mclk)
   begin
      tick_q <= reset_n ? tick_q + 2'h1 : 2'h0;
      br_ready <= !slow || tick_q[1];
      if (!reset_n || go)
         nrx <= 7'h00;
      else if (br_valid && br_ready)
      begin
         got[br_index] <= br_word;
         nrx <= nrx + 7'h01;
      end
      if (!reset_n)
         bw_valid <= 1'b0;
      else if (go)
         {bw_valid, bw_index} <= {1'b1, 6'h3f};
      else if (bw_valid && bw_ready)
         {bw_valid, bw_index} <= {bw_index != 6'h00, bw_index - 6'h01};
   end
endmodule

//--- verif/testbench.sv
// random setup blocks, slave requests and event codes against worked-out values
// assumes the controller model carries blocks; port 0 ends as slave, port 1 master
`timescale 1ns/1ps
module testbench;
   logic mclk = 0, reset_n = 0, go = 0, slow = 0, bw_valid, bw_last, bw_ready, br_valid, br_ready;
   logic [63:0][15:0] blk = 0, got;
   logic [6:0] nrx;
   logic [5:0] bw_index, br_index;
   logic [15:0] bw_word, br_word;
   logic [1:0] evt_valid = 0, cmd_chk = 0, cmd_adv = 0, req_valid = 0, pass = 0, slv_v, fwd, slv;
   logic [1:0] cmd_due;
   logic [1:0][6:0] cmd_idx;
   logic [1:0][7:0] func = 0;
   logic [1:0][15:0] exc, cur_err, last_err;
   mgc_pkg::mgc_rsp_s [1:0] rsp = 0;
   mgc_pkg::mgc_cmd_s [1:0] cmd = 0;
   logic [15:0] corner [14] = '{0, 1, 2, 3, 5, 8, 100, 101, 255, 256, 4999, 5000, 'hec78, 'hffff};
   logic [7:0] fc [10] = '{1, 2, 3, 4, 5, 6, 15, 16, 7, 43};
   int error_cnt = 0, check_count = 0, seed = 32'h6cee, cyc = 0, i, k;
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   mgc_plc_model u_plc (.*);
   mgc_gateway_check i_dut (.*, .rsp_in(rsp), .cmd_in(cmd), .exp_addr(16'h0000),
      .exp_func(16'h0000), .req_func(func), .pass_thru_en(pass), .slv_rsp_valid(slv_v),
      .slv_exc(exc), .slv_fwd(fwd), .port_is_slave(slv));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [3:0] area(logic [15:0] s, logic [15:0] c);
      return {$signed(s) + $signed(c) > 5000, $signed(c) < 0, $signed(s) < 0, $signed(s) > 5000};
   endfunction
   function automatic logic [15:0] perr(int b);
      logic bd;
      bd = 1;
      for (int j = 0; j < 12; j++)
         if (blk[b+6] == mgc_pkg::BAUD_CODES[j]) bd = 0;
      return {4'h0, blk[b+18] > 100, blk[b+14] > 4999 || blk[b+15] > 4999 || blk[b+16] > 4999
         || blk[b+17] > 4999, blk[b+13] > 255, !(blk[b+9] inside {[1:2]}),
         !(blk[b+8] inside {[5:8]}), blk[b+7] > 2, bd, blk[b+5] > 1, blk[b+4] > 4999,
         blk[b+3] > 4999, blk[b+2] > 1, blk[b+1] > 1};
   endfunction
   function automatic logic [15:0] rword(int n);
      case (n)
         0: return 16'hfffe;
         1: return 16'h2328;
         2: return {8'h00, area(blk[3], blk[4]), area(blk[1], blk[2])};
         3: return perr(7);
         4: return perr(32);
         default: return 16'h0000;
      endcase
   endfunction
   task automatic send_block(logic [15:0] id);
      blk[0] = id;
      go = 1;
      @(negedge mclk) go = 0;
      for (k = 0; k < 400 && nrx < 64; k++) @(negedge mclk);
   endtask
   initial
   begin
      repeat (5) @(negedge mclk);
      reset_n = 1;
      send_block(16'h2329);
      chk("no reply", 16'h0000, {9'h0, nrx});
      for (i = 0; i < 7; i++)
      begin
         for (k = 1; k < 64; k++) blk[k] = corner[$unsigned($random(seed)) % 14];
         blk[13] = mgc_pkg::BAUD_CODES[$unsigned($random(seed)) % 12];
         if (i == 6) {blk[8], blk[33], blk[50]} = {16'h1, 16'h0, 16'h3};
         slow = i[0];
         send_block(16'h2328);
         for (k = 0; k < 64; k++) chk("reply word", rword(k), got[k]);
      end
      for (i = 0; i < 10; i++)
      begin
         {func[0], pass[0], req_valid} = {fc[i], 1'($random(seed)), 2'b01};
         @(negedge mclk) req_valid = 0;
         chk("slave valid", 16'h0001, {15'h0, slv_v[0]});
         chk("slave exc", i < 8 ? 16'h0000 : 16'h0001, exc[0]);
         chk("forward", {15'h0, pass[0] && i inside {[4:7]}}, {15'h0, fwd[0]});
      end
      for (i = 0; i < 8; i++)
      begin
         @(negedge mclk) chk("master current", 16'(i % 3), cur_err[1]);
         cmd[0] = '{16'h1, 16'h0, 16'h1, 16'h0, 16'h1, 16'h3};
         case (i)
            0: cmd[0].enable = 3;
            1: cmd[0].int_addr = 5000;
            2: cmd[0].node = 256;
            3: cmd[0].count = 0;
            4: cmd[0].func = 7;
            5: cmd[0].swap = 4;
         endcase
         rsp[0] = '{0, 0, i == 6, 0, 0, 0, i != 7};
         {cmd_chk, evt_valid, cmd_adv} = {1'b0, i < 6, 4'b0110};
         @(negedge mclk) {evt_valid, cmd_adv} = 4'h0;
         chk("event code", i < 6 ? 16'hffd7 - i : (i == 6 ? 16'hfff5 : 16'h00ff), cur_err[0]);
         chk("cmd index", 16'((i + 1) % 3), {9'h0, cmd_idx[1]});
         chk("last error", i < 6 ? 16'hffd7 - i : (i == 6 ? 16'hfff5 : 16'h00ff), last_err[0]);
         chk("cmd due", 16'h0001, {15'h0, cmd_due[1]});
      end
      finish_test();
   end
endmodule
